// ---- rsss_top.v ----
// Reset source combiner and start-up sequencer with Wishbone registers
//
// Our own choices: the register offsets and the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none
`include "rsss_consts.vh"
module rsss_top #(
  parameter integer PWRUP_CYC = `RSSS_PWRUP_US * `RSSS_CLK_MHZ,
  parameter integer GLITCH_CYC = (`RSSS_GLITCH_NS * `RSSS_CLK_MHZ) / 1000
) (
  // Clock and reset
  input  wire        clk_sys_i,
  input  wire        rst_b_i,
  // Configuration word bits
  input  wire [1:0]  brownout_mode_cfg_i,
  input  wire        low_power_brownout_cfg_i,
  input  wire        master_clear_enable_cfg_i,
  input  wire        low_voltage_program_cfg_i,
  input  wire        stack_fault_reset_enable_i,
  input  wire        powerup_timer_enable_n_i,
  // Supply monitors and events
  input  wire        brownout_low_i,
  input  wire        lp_brownout_low_i,
  input  wire        sleep_i,
  input  wire        prog_mode_i,
  input  wire        watchdog_expire_i,
  input  wire        watchdog_clear_instr_i,
  input  wire        sleep_instr_i,
  input  wire        reset_instr_i,
  input  wire        stack_over_i,
  input  wire        stack_under_i,
  // Master-clear pin
  input  wire        master_clear_pin_i,
  output reg         master_clear_pin_o,
  output reg         master_clear_pin_oe_b_o,
  output reg         pin_pullup_en_o,
  output reg         pin_gpio_o,
  // Analogue controls and core reset
  output reg         bandgap_force_on_o,
  output reg         brownout_active_o,
  output reg         core_reset_o,
  // Wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [3:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o
);
  // Power-up counter width; PWRUP_CYC must stay below 2**PCW
  localparam integer PCW = 20;
  localparam [PCW-1:0] PWRUP_N = PWRUP_CYC[PCW-1:0];
  // Start delay after the filtered pin rises, in clock cycles
  localparam [3:0] START_N = `RSSS_START_CYC;

  // Sequencer states
  localparam [1:0] ST_PWR = 2'h0;
  localparam [1:0] ST_HOLD = 2'h1;
  localparam [1:0] ST_WAIT = 2'h2;
  localparam [1:0] ST_RUN = 2'h3;

  reg [1:0]     state_q;
  reg [PCW-1:0] pwr_cnt_q;
  reg           pwr_done_q;
  reg [3:0]     start_cnt_q;
  reg           sw_brownout_enable_q;
  reg           brownout_fast_start_q;
  reg           stack_over_flag_q;
  reg           stack_under_flag_q;
  reg           reset_instr_flag_q;
  reg           por_flag_q;
  reg           brownout_reset_flag_q;
  reg           timeout_flag_q;
  reg           powerdown_flag_q;
  reg           pin_pullup_sw_q;
  reg           prog_q;
  wire          pin_level;
  wire          master_clear_pin_en;
  wire          bor_en;
  wire          bor_trip;
  wire          lp_trip;
  wire          power_evt;
  wire          soft_evt;
  wire          master_clear_pin_low;
  wire          wb_req;

  // Glitch filter on the master-clear path
  // pin noise filter
  rsss_filter #(
    .LEN (GLITCH_CYC < 1 ? 1 : GLITCH_CYC),
    .CW  (4)
  ) u_filt (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .pin_i     (master_clear_pin_i),
    .level_o   (pin_level)
  );

  assign master_clear_pin_en = master_clear_enable_cfg_i | low_voltage_program_cfg_i;
  assign master_clear_pin_low = master_clear_pin_en & ~pin_level;

  // Brown-out enable decoded from mode, software bit and sleep
  function bor_enable;
    input [1:0] mode;
    input       swen;
    input       slp;
    begin
      case (mode)
        `RSSS_BM_ON:    bor_enable = 1'b1;
        `RSSS_BM_NOSLP: bor_enable = ~slp;
        `RSSS_BM_SW:    bor_enable = swen;
        default:        bor_enable = 1'b0;
      endcase
    end
  endfunction

  assign bor_en = bor_enable(brownout_mode_cfg_i, sw_brownout_enable_q, sleep_i);
  assign bor_trip = bor_en & brownout_low_i;
  assign lp_trip = low_power_brownout_cfg_i & lp_brownout_low_i;
  // Programming mode holds reset; its exit restarts as from power-on
  assign power_evt = bor_trip | lp_trip | (prog_q & ~prog_mode_i) | prog_mode_i;
  // Instruction, watchdog and stack resets skip the power-up timer
  // enabled stack faults
  assign soft_evt = watchdog_expire_i | reset_instr_i
                  | (stack_fault_reset_enable_i & (stack_over_i | stack_under_i));
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  // Start-up sequencer
  // combined reset release
  always @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      state_q     <= ST_PWR;
      pwr_cnt_q   <= {PCW{1'b0}};
      pwr_done_q  <= 1'b0;
      start_cnt_q <= 4'h0;
      prog_q      <= 1'b0;
    end else begin
      prog_q <= prog_mode_i;
      if (power_evt) begin
        state_q     <= ST_PWR;
        pwr_cnt_q   <= {PCW{1'b0}};
        pwr_done_q  <= 1'b0;
        start_cnt_q <= 4'h0;
      end else begin
        if (!pwr_done_q) begin
          if (powerup_timer_enable_n_i || pwr_cnt_q == PWRUP_N - 1'b1) begin
            pwr_done_q <= 1'b1;
          end else begin
            pwr_cnt_q <= pwr_cnt_q + 1'b1;
          end
        end
        case (state_q)
          ST_PWR: begin
            if (pwr_done_q || powerup_timer_enable_n_i) begin
              state_q <= ST_HOLD;
            end
          end
          ST_HOLD: begin
            if (!master_clear_pin_low && !soft_evt) begin
              state_q     <= ST_WAIT;
              start_cnt_q <= 4'h0;
            end
          end
          ST_WAIT: begin
            if (master_clear_pin_low || soft_evt) begin
              state_q <= ST_HOLD;
            end else if (start_cnt_q == START_N - 1'b1) begin
              state_q <= ST_RUN;
            end else begin
              start_cnt_q <= start_cnt_q + 1'b1;
            end
          end
          ST_RUN: begin
            if (master_clear_pin_low || soft_evt) begin
              state_q <= ST_HOLD;
            end
          end
          default: state_q <= ST_PWR;
        endcase
      end
    end
  end

  // Reset cause flags; hardware update wins over software write
  always @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      stack_over_flag_q     <= 1'b0;
      stack_under_flag_q    <= 1'b0;
      reset_instr_flag_q    <= 1'b1;
      por_flag_q            <= 1'b0;
      brownout_reset_flag_q <= 1'b0;
      timeout_flag_q        <= 1'b1;
      powerdown_flag_q      <= 1'b1;
    end else begin
      if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == `RSSS_ADR_PWRCTL) begin
        stack_over_flag_q     <= wb_dat_i[`RSSS_PC_OVF];
        stack_under_flag_q    <= wb_dat_i[`RSSS_PC_UNF];
        reset_instr_flag_q    <= wb_dat_i[`RSSS_PC_RI];
        por_flag_q            <= wb_dat_i[`RSSS_PC_POR];
        brownout_reset_flag_q <= wb_dat_i[`RSSS_PC_BOR];
      end
      if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == `RSSS_ADR_STATUS) begin
        timeout_flag_q   <= wb_dat_i[`RSSS_ST_TO];
        powerdown_flag_q <= wb_dat_i[`RSSS_ST_PD];
      end
      // Sleep and watchdog-clear instructions update the status flags
      if (watchdog_clear_instr_i) begin
        timeout_flag_q   <= 1'b1;
        powerdown_flag_q <= 1'b1;
      end
      if (sleep_instr_i) begin
        timeout_flag_q   <= 1'b1;
        powerdown_flag_q <= 1'b0;
      end
      if (watchdog_expire_i) begin
        timeout_flag_q   <= 1'b0;
        powerdown_flag_q <= ~sleep_i;
      end
      if (reset_instr_i) begin
        reset_instr_flag_q <= 1'b0;
      end
      if (stack_fault_reset_enable_i && stack_over_i) begin
        stack_over_flag_q <= 1'b1;
      end
      if (stack_fault_reset_enable_i && stack_under_i) begin
        stack_under_flag_q <= 1'b1;
      end
      if (bor_trip || lp_trip) begin
        brownout_reset_flag_q <= 1'b0;
      end
      if (prog_q && !prog_mode_i) begin
        por_flag_q <= 1'b0;
      end
    end
  end

  // Software bits and Wishbone answer
  always @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      sw_brownout_enable_q  <= 1'b1;
      brownout_fast_start_q <= 1'b0;
      pin_pullup_sw_q       <= 1'b1;
      wb_ack_o              <= 1'b0;
      wb_dat_o              <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && wb_we_i && wb_sel_i[0]) begin
        if (wb_adr_i == `RSSS_ADR_BORCTL) begin
          sw_brownout_enable_q  <= wb_dat_i[`RSSS_BC_SWEN];
          brownout_fast_start_q <= wb_dat_i[`RSSS_BC_FAST];
        end
        if (wb_adr_i == `RSSS_ADR_PINCTL) begin
          pin_pullup_sw_q <= wb_dat_i[0];
        end
      end
      wb_dat_o <= 32'h0000_0000;
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          `RSSS_ADR_BORCTL: wb_dat_o[7:0] <= {sw_brownout_enable_q, brownout_fast_start_q,
                                            5'h00, brownout_active_o};
          `RSSS_ADR_PWRCTL: wb_dat_o[7:0] <= {stack_over_flag_q, stack_under_flag_q, 3'h0,
                                            reset_instr_flag_q, por_flag_q,
                                            brownout_reset_flag_q};
          `RSSS_ADR_STATUS: wb_dat_o[7:0] <= {3'h0, timeout_flag_q, powerdown_flag_q, 3'h0};
          `RSSS_ADR_PINCTL: wb_dat_o[7:0] <= {5'h00, master_clear_pin_en, pin_level, pin_pullup_sw_q};
          default:          wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Registered outputs
  always @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      core_reset_o            <= 1'b1;
      brownout_active_o       <= 1'b0;
      bandgap_force_on_o      <= 1'b0;
      master_clear_pin_o      <= 1'b0;
      master_clear_pin_oe_b_o <= 1'b1;
      pin_pullup_en_o         <= 1'b1;
      pin_gpio_o              <= 1'b1;
    end else begin
      // Any live source asserts reset within one cycle
      core_reset_o      <= (state_q != ST_RUN) | power_evt | master_clear_pin_low | soft_evt;
      brownout_active_o <= bor_en;
      bandgap_force_on_o <= brownout_fast_start_q &
                            (brownout_mode_cfg_i == `RSSS_BM_NOSLP ||
                             brownout_mode_cfg_i == `RSSS_BM_SW);
      master_clear_pin_o      <= 1'b0;
      master_clear_pin_oe_b_o <= 1'b1;
      pin_pullup_en_o <= master_clear_pin_en ? 1'b1 : pin_pullup_sw_q;
      pin_gpio_o      <= master_clear_pin_en ? 1'b1 : pin_level;
    end
  end
endmodule // rsss_top
`default_nettype wire

// ---- rsss_consts.vh ----
// Constants for the reset source combiner and start-up sequencer
`ifndef RSSS_CONSTS_VH
`define RSSS_CONSTS_VH

// Register word offsets (byte addresses)
`define RSSS_ADR_BORCTL   4'h0
`define RSSS_ADR_PWRCTL   4'h4
`define RSSS_ADR_STATUS   4'h8
`define RSSS_ADR_PINCTL   4'hC

// Brown-out control register fields
`define RSSS_BC_SWEN      7
`define RSSS_BC_FAST      6
`define RSSS_BC_RDY       0
`define RSSS_BC_RESET     2'h2

// Power control register fields
`define RSSS_PC_OVF       7
`define RSSS_PC_UNF       6
`define RSSS_PC_RI        2
`define RSSS_PC_POR       1
`define RSSS_PC_BOR       0

// Status register fields
`define RSSS_ST_TO        4
`define RSSS_ST_PD        3

// Brown-out mode encodings
`define RSSS_BM_OFF       2'h0
`define RSSS_BM_SW        2'h1
`define RSSS_BM_NOSLP     2'h2
`define RSSS_BM_ON        2'h3

// Timing
`define RSSS_CLK_MHZ      25
`define RSSS_PWRUP_US     64
`define RSSS_GLITCH_NS    200
`define RSSS_START_CYC    4'hA

`endif

// ---- rsss_filter.v ----
// Three-stage synchroniser with a glitch filter for an external pin
`timescale 1ns/100ps
`default_nettype none
module rsss_filter #(
  parameter integer LEN = 5,
  parameter integer CW  = 4
) (
  // Clock and reset
  input  wire clk_sys_i,
  input  wire rst_b_i,
  // Pin and result
  input  wire pin_i,
  output reg  level_o
);
  reg [2:0]    sync_q;
  reg [CW-1:0] cnt_q;

  // Synchronise; stage 0 feeds only stage 1
  always @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      sync_q  <= 3'h7;
      cnt_q   <= {CW{1'b0}};
      level_o <= 1'b1;
    end else begin
      sync_q <= {sync_q[1:0], pin_i};
      // Stable level must persist LEN cycles before it is accepted
      if (sync_q[1] == sync_q[2] && sync_q[2] != level_o) begin
        if (cnt_q == LEN[CW-1:0] - 1'b1) begin
          level_o <= sync_q[2];
          cnt_q   <= {CW{1'b0}};
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end else begin
        cnt_q <= {CW{1'b0}};
      end
    end
  end
endmodule // rsss_filter
`default_nettype wire

// ---- rsss_assertions.sv ----
// Checker for the reset sequencer ports
`timescale 1ns/100ps
`default_nettype none
module rsss_chk (
  // Clock, reset and configuration
  input wire logic       clk_sys_i,
  input wire logic       rst_b_i,
  input wire logic [1:0] brownout_mode_cfg_i,
  input wire logic       low_power_brownout_cfg_i,
  input wire logic       master_clear_enable_cfg_i,
  input wire logic       low_voltage_program_cfg_i,
  // Events and pin
  input wire logic       lp_brownout_low_i,
  input wire logic       watchdog_expire_i,
  input wire logic       reset_instr_i,
  input wire logic       master_clear_pin_i,
  // Watched outputs
  input wire logic       master_clear_pin_oe_b_o,
  input wire logic       pin_gpio_o,
  input wire logic       bandgap_force_on_o,
  input wire logic       core_reset_o
);
  // Pin function enabled by either bit
  wire logic en = master_clear_enable_cfg_i | low_voltage_program_cfg_i;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  a_pin_not_driven: assert property (master_clear_pin_oe_b_o)
    else $error("pin driven");
  a_instr_resets: assert property (reset_instr_i |=> core_reset_o)
    else $error("no reset after instruction");
  a_watchdog_resets: assert property (watchdog_expire_i |=> core_reset_o)
    else $error("no reset after watchdog");
  a_lp_holds: assert property (
    low_power_brownout_cfg_i && lp_brownout_low_i |=> core_reset_o) else $error("lp not held");
  a_bandgap_idle: assert property ($stable(brownout_mode_cfg_i) &&
    brownout_mode_cfg_i[1] == brownout_mode_cfg_i[0] |=> !bandgap_force_on_o)
    else $error("band gap forced");
  a_pin_low_resets: assert property (
    (en && !master_clear_pin_i) [*8] |-> ##[0:3] core_reset_o) else $error("pin low ignored");
  a_gpio_fn_on: assert property (en && $past(en) |-> pin_gpio_o)
    else $error("gpio not high");
  a_release_pin: assert property (
    en && $fell(core_reset_o) |-> $past(master_clear_pin_i, 11)) else $error("early run");
endmodule // rsss_chk
bind rsss_top rsss_chk u_chk (.*);
`default_nettype wire

// ---- rsss_partner.sv ----
// Model of the external pin driver and supply monitors
`timescale 1ns/100ps
`default_nettype none
module rsss_partner (
  // Clock and bench controls
  input wire logic clk_sys_i,
  input wire logic hold_low_i,
  input wire logic sag_i,
  input wire logic lp_sag_i,
  // Device pin controls
  input wire logic pin_o_i,
  input wire logic pin_oe_b_i,
  input wire logic pullup_i,
  // Pin level and monitors
  output logic     pin_level_o,
  output logic     brownout_low_o,
  output logic     lp_brownout_low_o
);
  logic float_q = 1'h0;
  // An undriven pin without pull-up wanders
  always @(posedge clk_sys_i) begin
    float_q <= ~float_q;
  end
  // Wired level of the pin
  always_comb begin
    if (hold_low_i || (!pin_oe_b_i && !pin_o_i))
      pin_level_o = 1'h0;
    else if (pullup_i)
      pin_level_o = 1'h1;
    else
      pin_level_o = float_q;
  end
  // Supply monitors follow the bench
  assign brownout_low_o = sag_i;
  assign lp_brownout_low_o = lp_sag_i;
endmodule // rsss_partner
`default_nettype wire

// ---- rsss_tb.sv ----
// Self-checking bench for the reset sequencer
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam int P = 20;
  // Bench-driven inputs
  logic clk_sys_i = 1'h0, rst_b_i = 1'h0, sleep_i = 1'h0, prog_mode_i = 1'h0;
  logic [1:0] brownout_mode_cfg_i = 2'h0;
  logic low_power_brownout_cfg_i = 1'h0, master_clear_enable_cfg_i = 1'h1;
  logic low_voltage_program_cfg_i = 1'h0, stack_fault_reset_enable_i = 1'h1;
  logic powerup_timer_enable_n_i = 1'h0, watchdog_expire_i = 1'h0, reset_instr_i = 1'h0;
  logic watchdog_clear_instr_i = 1'h0, sleep_instr_i = 1'h0, stack_under_i = 1'h0;
  logic stack_over_i = 1'h0, hold = 1'h1, sag = 1'h0, lpsag = 1'h0, sw, v;
  logic wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0;
  logic [7:0] rd;
  int errors = 0, checks_done = 0, n;
  // Design outputs and far-side lines
  wire logic master_clear_pin_i, brownout_low_i, lp_brownout_low_i, master_clear_pin_o;
  wire logic master_clear_pin_oe_b_o, pin_pullup_en_o, pin_gpio_o, bandgap_force_on_o;
  wire logic brownout_active_o, core_reset_o, wb_ack_o;
  wire logic [31:0] wb_dat_o;
  rsss_top #(.PWRUP_CYC(P)) DUT (.*);
  rsss_partner u_far (.clk_sys_i(clk_sys_i), .hold_low_i(hold), .sag_i(sag),
    .lp_sag_i(lpsag), .pin_o_i(master_clear_pin_o), .pin_oe_b_i(master_clear_pin_oe_b_o),
    .pullup_i(pin_pullup_en_o), .pin_level_o(master_clear_pin_i),
    .brownout_low_o(brownout_low_i), .lp_brownout_low_o(lp_brownout_low_i));
  // 25 MHz clock
  always #20 clk_sys_i = ~clk_sys_i;
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys_i);
  endtask
  // One classic Wishbone cycle, held until ack
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    int k;
    @(posedge clk_sys_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= w;
    wb_sel_i <= 4'hF;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    k = 0;
    do begin
      @(posedge clk_sys_i);
      k++;
    end while (wb_ack_o !== 1'h1 && k < 50);
    if (k >= 50) begin
      errors++;
      end_sim();
    end
    rd = wb_dat_o[7:0];
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask
  // One-cycle event pulse: 0 reset instr, 1 watchdog, 2 over, 3 under, 4 clear, 5 sleep
  task automatic pulse(input int s);
    logic [5:0] p;
    p = 6'h01 << s;
    @(posedge clk_sys_i);
    {sleep_instr_i, watchdog_clear_instr_i, stack_under_i} <= p[5:3];
    {stack_over_i, watchdog_expire_i, reset_instr_i} <= p[2:0];
    @(posedge clk_sys_i);
    {sleep_instr_i, watchdog_clear_instr_i, stack_under_i} <= 3'h0;
    {stack_over_i, watchdog_expire_i, reset_instr_i} <= 3'h0;
    @(posedge clk_sys_i);
  endtask
  // Cycles until the core leaves reset, bounded
  task automatic rel_wait(output int c);
    c = 0;
    while (core_reset_o !== 1'h0 && c < 500) begin
      @(posedge clk_sys_i);
      c++;
    end
    if (c >= 500) begin
      errors++;
      end_sim();
    end
  endtask
  initial begin
    void'($urandom(24));
    cyc(6);
    rst_b_i <= 1'h1;
    cyc(P + 20);
    chk(core_reset_o, 1'h1);
    hold <= 1'h0;
    rel_wait(n);
    chk(n >= 16 && n <= 24, 1'h1);
    wb(1'h0, 4'h0, 8'h00);
    chk(rd, 8'h80);
    wb(1'h0, 4'h1, 8'h00);
    chk(rd, 8'h00);
    for (int i = 0; i < 4; i++) begin
      {master_clear_enable_cfg_i, low_voltage_program_cfg_i} <= 2'(i);
      cyc(2);
      wb(1'h0, 4'hC, 8'h00);
      chk(rd[2], i != 0);
    end
    {master_clear_enable_cfg_i, low_voltage_program_cfg_i} <= 2'h0;
    for (int i = 0; i < 4; i++) begin
      sw = 1'($urandom);
      wb(1'h1, 4'hC, {7'h0, sw});
      cyc(2);
      chk(pin_pullup_en_o, sw);
    end
    wb(1'h1, 4'hC, 8'h01);
    hold <= 1'h1;
    cyc(20);
    chk({core_reset_o, pin_gpio_o}, 2'h0);
    hold <= 1'h0;
    cyc(20);
    master_clear_enable_cfg_i <= 1'h1;
    for (int i = 0; i < 4; i++) begin
      hold <= 1'h1;
      repeat (1 + $urandom % 3) @(posedge clk_sys_i);
      hold <= 1'h0;
      cyc(20);
      chk(core_reset_o, 1'h0);
    end
    $display("pin tests done");
    for (int m = 0; m < 5; m++) begin
      sw = 1'($urandom);
      brownout_mode_cfg_i <= (m == 4) ? 2'h2 : 2'(m);
      sleep_i <= (m == 4);
      wb(1'h1, 4'h0, {sw, 7'h40});
      cyc(2);
      v = m == 3 || m == 2 || (m == 1 && sw);
      chk(brownout_active_o, v);
      chk(bandgap_force_on_o, m == 1 || m == 2 || m == 4);
      wb(1'h0, 4'h0, 8'h00);
      chk(rd, {sw, 6'h20, v});
    end
    sleep_i <= 1'h0;
    brownout_mode_cfg_i <= 2'h1;
    wb(1'h1, 4'h0, 8'h00);
    {sag, lpsag} <= 2'h3;
    cyc(6);
    chk(core_reset_o, 1'h0);
    {sag, lpsag} <= 2'h0;
    wb(1'h1, 4'h0, 8'h80);
    low_power_brownout_cfg_i <= 1'h1;
    for (int s = 0; s < 2; s++) begin
      wb(1'h1, 4'h4, 8'hFF);
      {sag, lpsag} <= s ? 2'h1 : 2'h2;
      cyc(5);
      chk(core_reset_o, 1'h1);
      {sag, lpsag} <= 2'h0;
      rel_wait(n);
      wb(1'h0, 4'h4, 8'h00);
      chk(rd[0], 1'h0);
    end
    $display("brown-out tests done");
    wb(1'h1, 4'h4, 8'hFF);
    pulse(0);
    rel_wait(n);
    chk(n <= 15, 1'h1);
    wb(1'h0, 4'h4, 8'h00);
    chk(rd[2], 1'h0);
    pulse(1);
    chk(core_reset_o, 1'h1);
    rel_wait(n);
    wb(1'h0, 4'h8, 8'h00);
    chk(rd, 8'h08);
    pulse(4);
    wb(1'h0, 4'h8, 8'h00);
    chk(rd, 8'h18);
    pulse(5);
    wb(1'h0, 4'h8, 8'h00);
    chk(rd, 8'h10);
    wb(1'h1, 4'h4, 8'h06);
    pulse(2);
    chk(core_reset_o, 1'h1);
    rel_wait(n);
    stack_fault_reset_enable_i <= 1'h0;
    pulse(3);
    chk(core_reset_o, 1'h0);
    wb(1'h0, 4'h4, 8'h00);
    chk(rd[7:6], 2'h2);
    for (int t = 0; t < 2; t++) begin
      powerup_timer_enable_n_i <= 1'(t);
      prog_mode_i <= 1'h1;
      cyc(5);
      prog_mode_i <= 1'h0;
      cyc(2);
      rel_wait(n);
      chk(n + 1 >= P, t == 0);
    end
    wb(1'h0, 4'h4, 8'h00);
    chk(rd[1], 1'h0);
    chk({master_clear_pin_o, master_clear_pin_oe_b_o}, 8'h01);
    $display("event tests done");
    end_sim();
  end
endmodule // testbench
`default_nettype wire
